/* File: deec_regs.vh */
`ifndef DEEC_REGS_VH
`define DEEC_REGS_VH
// ==========================================================
// Functional notes
// - 256 sixteen-bit words ending at top address
// - Bus never stalls during erase or write
// - Key register reads back as zero
// - 55h then AAh arms one start write
// - Start bit set-only, cleared by hardware
// - Write enable needed, cleared on finish
// - Error flag set on pin/watchdog abort
// - Program-only skips erase, else auto-erase
// - Erase select picks erase or write
// - Commands erase eight, four or one word
// - Command 0100xx erases whole array
// - Command 0001xx writes latch word
// - Low command bits choose erase size
// - Control bits 11..7 read zero
// - Table write captures 24-bit address
// - Captured address not visible to software
// - Captured address bit 0 and 23 zero
// - High-word table access has no effect
// - Completion sets flag, clears start bit
// - Bulk erase ignores captured address
// ==========================================================
// Register offsets
`define DEEC_OFF_CTRL   8'h00
`define DEEC_OFF_KEY    8'h04
`define DEEC_OFF_STAT   8'h08
`define DEEC_OFF_PAGE   8'h0c
`define DEEC_OFF_TOFS   8'h10
`define DEEC_OFF_TLOW   8'h14
`define DEEC_OFF_THIGH  8'h18
// Control fields
`define DEEC_B_START    15
`define DEEC_B_WRITE_ENABLE_BIT     14
`define DEEC_B_ERR      13
`define DEEC_B_PGM      12
`define DEEC_B_ERASE    6
`define DEEC_CTRL_RST   16'h0000
`define DEEC_CTRL_WMSK  16'h707f
// Status fields
`define DEEC_B_FLAG     0
`define DEEC_B_BUSY     1
// Key values
`define DEEC_KEY1       8'h55
`define DEEC_KEY2       8'haa
// Commands
`define DEEC_OP_E8      6'h1a
`define DEEC_OP_E4      6'h19
`define DEEC_OP_E1      6'h18
`define DEEC_OP_BULK    4'h4
`define DEEC_OP_WORD    4'h1
`define DEEC_N8         9'h008
`define DEEC_N4         9'h004
`define DEEC_N1         9'h001
`define DEEC_NALL       9'h100
// Address map
`define DEEC_BASE       24'h7ffe00
`define DEEC_TOP        24'h7fffff
`define DEEC_ERASED     16'hffff
`endif

/* File: deec_mem.v */
`timescale 1ns/100ps
// ==========================================================
// Word array with one write and two read ports
module deec_mem #(
  parameter AW    = 8,
  parameter DEPTH = 256
) (
  input  wire          pclk,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [15:0]   wdata,
  input  wire [AW-1:0] raddr,
  output wire [15:0]   rdata,
  output wire [15:0]   wold
);
  reg [15:0] mem_q [0:DEPTH-1];

  always @(posedge pclk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  assign rdata = mem_q[raddr];
  assign wold  = mem_q[waddr];
endmodule // deec_mem

/* File: deec_unlock.v */
`timescale 1ns/100ps
`include "deec_regs.vh"
// ==========================================================
// Key sequence tracker
module deec_unlock (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       key_wr,
  input  wire [7:0] key_data,
  input  wire       other_wr,
  output wire       unlocked
);
  localparam S_NONE = 2'd0;
  localparam S_HALF = 2'd1;
  localparam S_OPEN = 2'd2;

  reg [1:0] st_q;
  reg [1:0] st_d;

  always @* begin
    st_d = st_q;
    if (key_wr) begin
      case (st_q)
        S_HALF:  st_d = (key_data == `DEEC_KEY2) ? S_OPEN :
                        (key_data == `DEEC_KEY1) ? S_HALF : S_NONE;
        default: st_d = (key_data == `DEEC_KEY1) ? S_HALF : S_NONE;
      endcase
    end else if (other_wr) begin
      st_d = S_NONE;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  assign unlocked = (st_q == S_OPEN);
endmodule // deec_unlock

/* File: deec_ctrl.v */
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "deec_regs.vh"
// ==========================================================
// Data EEPROM controller, APB slave
module deec_ctrl #(
  parameter AW       = 8,
  parameter DEPTH    = 256,
  parameter OP_WAIT  = 16'h0040
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire        abort_pin_reset,
  input  wire        abort_watchdog,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         busy_q,
  output reg         memory_interrupt_flag
);
  // ========================================================
  // State encoding
  localparam S_IDLE = 2'd0;
  localparam S_WAIT = 2'd1;
  localparam S_STEP = 2'd2;

  // ========================================================
  // Declarations
  reg  [1:0]    st_q;
  reg  [1:0]    st_d;
  reg  [15:0]   ctrl_q;
  reg  [15:0]   ctrl_d;
  reg  [7:0]    page_q;
  reg  [15:0]   tofs_q;
  reg  [7:0]    cap_hi_q;
  reg  [15:0]   cap_lo_q;
  reg  [15:0]   latch_q;
  reg  [15:0]   wait_q;
  reg  [15:0]   wait_d;
  reg  [8:0]    left_q;
  reg  [8:0]    left_d;
  reg  [AW-1:0] idx_q;
  reg  [AW-1:0] idx_d;
  reg           is_wr_q;
  reg           is_wr_d;
  reg           pgm_q;
  reg           pgm_d;
  reg           skip_d;
  reg           done;
  reg           abort;
  reg  [8:0]    n_sel;
  reg  [15:0]   wdata_m;
  reg  [31:0]   rd_d;
  reg           err_d;
  reg           mem_we;
  reg  [15:0]   mem_wd;
  wire          acc;
  wire          setup;
  wire          wr_acc;
  wire          wr_ctrl;
  wire          wr_key;
  wire          wr_stat;
  wire          wr_tlow;
  wire          unlocked;
  wire          go;
  wire [23:0]   cap_addr;
  wire [23:0]   rd_addr;
  wire          cap_in;
  wire          rd_in;
  wire [15:0]   mem_rd;
  wire [15:0]   mem_old;
  wire [5:0]    op;
  wire          is_bulk;
  wire          wr_page;
  wire          wr_tofs;

  // ========================================================
  // Bus decode
  assign acc     = psel & penable & pready;
  assign setup   = psel & ~penable;
  assign wr_acc  = acc & pwrite;
  assign wr_ctrl = wr_acc & (paddr == `DEEC_OFF_CTRL);
  assign wr_key  = wr_acc & (paddr == `DEEC_OFF_KEY);
  assign wr_stat = wr_acc & (paddr == `DEEC_OFF_STAT);
  assign wr_tlow = wr_acc & (paddr == `DEEC_OFF_TLOW);
  assign wr_page = wr_acc & (paddr == `DEEC_OFF_PAGE);
  assign wr_tofs = wr_acc & (paddr == `DEEC_OFF_TOFS);
  assign op      = pwdata[5:0];
  assign is_bulk = pwdata[`DEEC_B_ERASE] & (op[5:2] == `DEEC_OP_BULK);

  // ========================================================
  // Address windows
  assign cap_addr = {cap_hi_q, cap_lo_q};
  assign rd_addr  = {page_q, tofs_q};
  assign cap_in   = (cap_addr >= `DEEC_BASE);
  assign rd_in    = (rd_addr >= `DEEC_BASE)
                  & (rd_addr <= `DEEC_TOP);

  // ========================================================
  // Unlock tracker
  deec_unlock u_unlock (
    .pclk     (pclk),
    .presetn  (presetn),
    .key_wr   (wr_key),
    .key_data (pwdata[7:0]),
    .other_wr (wr_acc & ~wr_key),
    .unlocked (unlocked)
  );

  // ========================================================
  // Array
  deec_mem #(
    .AW    (AW),
    .DEPTH (DEPTH)
  ) u_mem (
    .pclk  (pclk),
    .we    (mem_we),
    .waddr (idx_q),
    .wdata (mem_wd),
    .raddr (tofs_q[AW:1]),
    .rdata (mem_rd),
    .wold  (mem_old)
  );

  // ========================================================
  // Start qualification
  assign go = wr_ctrl & unlocked & (st_q == S_IDLE)
            & pwdata[`DEEC_B_START] & pwdata[`DEEC_B_WRITE_ENABLE_BIT];

  // ========================================================
  // Operation decode
  always @* begin
    n_sel  = 9'h000;
    skip_d = 1'b1;
    case (op)
      `DEEC_OP_E8: n_sel = `DEEC_N8;
      `DEEC_OP_E4: n_sel = `DEEC_N4;
      `DEEC_OP_E1: n_sel = `DEEC_N1;
      default:     n_sel = 9'h000;
    endcase
    if (pwdata[`DEEC_B_ERASE]) begin
      if (is_bulk) begin
        n_sel  = `DEEC_NALL;
        skip_d = 1'b0;
      end else begin
        skip_d = ~cap_in | (n_sel == 9'h000);
      end
    end else begin
      n_sel  = (op[5:2] == `DEEC_OP_WORD) ? `DEEC_N1 : 9'h000;
      skip_d = ~cap_in | (n_sel == 9'h000);
    end
  end

  // ========================================================
  // Engine
  always @* begin
    st_d    = st_q;
    wait_d  = wait_q;
    left_d  = left_q;
    idx_d   = idx_q;
    is_wr_d = is_wr_q;
    pgm_d   = pgm_q;
    done    = 1'b0;
    mem_we  = 1'b0;
    mem_wd  = `DEEC_ERASED;
    abort   = (st_q != S_IDLE) & (abort_pin_reset | abort_watchdog);
    case (st_q)
      S_IDLE: begin
        if (go) begin
          st_d    = S_WAIT;
          wait_d  = OP_WAIT;
          left_d  = skip_d ? 9'h000 : n_sel;
          is_wr_d = ~pwdata[`DEEC_B_ERASE];
          pgm_d   = pwdata[`DEEC_B_PGM];
          if (is_bulk) begin
            idx_d = {AW{1'b0}};
          end else begin
            idx_d = cap_lo_q[AW:1];
          end
        end
      end
      S_WAIT: begin
        if (wait_q == 16'h0000) begin
          st_d = S_STEP;
        end else begin
          wait_d = wait_q - 16'h0001;
        end
      end
      S_STEP: begin
        if (left_q == 9'h000) begin
          st_d = S_IDLE;
          done = 1'b1;
        end else begin
          mem_we = 1'b1;
          if (is_wr_q) begin
            mem_wd = pgm_q ? (mem_old & latch_q) : latch_q;
          end
          left_d = left_q - 9'h001;
          idx_d  = idx_q + {{(AW-1){1'b0}}, 1'b1};
          if (idx_q == {AW{1'b1}}) begin
            left_d = 9'h000;
          end
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
    if (abort) begin
      st_d   = S_IDLE;
      mem_we = 1'b0;
      done   = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= S_IDLE;
      wait_q  <= 16'h0000;
      left_q  <= 9'h000;
      idx_q   <= {AW{1'b0}};
      is_wr_q <= 1'b0;
      pgm_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      wait_q  <= wait_d;
      left_q  <= left_d;
      idx_q   <= idx_d;
      is_wr_q <= is_wr_d;
      pgm_q   <= pgm_d;
    end
  end

  // ========================================================
  // Control register
  always @* begin
    ctrl_d  = ctrl_q;
    wdata_m = pwdata[15:0] & `DEEC_CTRL_WMSK;
    err_d   = ctrl_q[`DEEC_B_ERR];
    if (wr_ctrl && st_q == S_IDLE) begin
      ctrl_d = wdata_m;
      err_d  = wdata_m[`DEEC_B_ERR];
    end
    if (go) begin
      ctrl_d[`DEEC_B_START] = 1'b1;
    end
    if (done || abort) begin
      ctrl_d[`DEEC_B_START] = 1'b0;
      ctrl_d[`DEEC_B_WRITE_ENABLE_BIT]  = 1'b0;
    end
    if (done) begin
      err_d = 1'b0;
    end
    if (abort) begin
      err_d = 1'b1;
    end
    ctrl_d[`DEEC_B_ERR] = err_d;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `DEEC_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ========================================================
  // Table pointer and address capture
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_q   <= 8'h00;
      tofs_q   <= 16'h0000;
      cap_hi_q <= 8'h00;
      cap_lo_q <= 16'h0000;
      latch_q  <= 16'h0000;
    end else begin
      if (wr_page) begin
        page_q <= pwdata[7:0];
      end
      if (wr_tofs) begin
        tofs_q <= pwdata[15:0];
      end
      if (wr_tlow) begin
        cap_hi_q <= {1'b0, page_q[6:0]};
        cap_lo_q <= {tofs_q[15:1], 1'b0};
        latch_q  <= pwdata[15:0];
      end
    end
  end

  // ========================================================
  // Completion flag and busy
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      memory_interrupt_flag <= 1'b0;
      busy_q                <= 1'b0;
    end else begin
      if (done) begin
        memory_interrupt_flag <= 1'b1;
      end else if (wr_stat && pwdata[`DEEC_B_FLAG]) begin
        memory_interrupt_flag <= 1'b0;
      end
      busy_q <= (st_d != S_IDLE);
    end
  end

  // ========================================================
  // Read mux, taken in the setup phase
  always @* begin
    rd_d = 32'h00000000;
    case (paddr)
      `DEEC_OFF_CTRL:  rd_d = {16'h0000, ctrl_q};
      `DEEC_OFF_KEY:   rd_d = 32'h00000000;
      `DEEC_OFF_STAT:  rd_d = {30'h00000000, busy_q, memory_interrupt_flag};
      `DEEC_OFF_PAGE:  rd_d = {24'h000000, page_q};
      `DEEC_OFF_TOFS:  rd_d = {16'h0000, tofs_q};
      `DEEC_OFF_TLOW: begin
        rd_d = (rd_in & ~busy_q) ? {16'h0000, mem_rd} : 32'h00000000;
      end
      `DEEC_OFF_THIGH: rd_d = 32'h00000000;
      default:         rd_d = 32'h00000000;
    endcase
  end

  // ========================================================
  // APB answer, never stalled by the engine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata  <= rd_d;
        pslverr <= (paddr > `DEEC_OFF_THIGH) | (paddr[1:0] != 2'b00);
      end
    end
  end
endmodule // deec_ctrl

/* File: deec_props_properties.sv */
`timescale 1ns/100ps
// ==========================================================
// Port checker
module deec_props (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        abort_pin_reset,
  input wire        abort_watchdog,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        busy_q,
  input wire        memory_interrupt_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_setup = psel && !penable && !pwrite;
  wire abort_any = abort_pin_reset || abort_watchdog;
  // ==========================================================
  // Assertions
  no_stall_a: assert property (psel && penable |-> pready)
    else $error("access phase not answered at once");
  key_hidden_a: assert property (rd_setup && paddr == 8'h04 |=> prdata == 32'h0)
    else $error("key register read not zero");
  ctrl_unimpl_a: assert property (rd_setup && paddr == 8'h00 |=> prdata[11:7] == 5'h00)
    else $error("control bits 11..7 not zero");
  high_word_a: assert property (rd_setup && paddr == 8'h18 |=> prdata == 32'h0)
    else $error("high table word not zero");
  start_cause_a: assert property ($rose(busy_q) |->
      $past(psel && penable && pwrite && paddr == 8'h00 && pwdata[15] && pwdata[14]))
    else $error("operation began without an enabled start write");
  done_flag_a: assert property ($rose(memory_interrupt_flag) |-> $fell(busy_q))
    else $error("completion flag without end of operation");
  op_bound_a: assert property ($rose(busy_q) |-> ##[1:1000] !busy_q)
    else $error("operation never finished");
  abort_stop_a: assert property (busy_q && abort_any |=>
      !busy_q && !$rose(memory_interrupt_flag))
    else $error("abort did not stop the operation");
  unmapped_a: assert property (psel && !penable && (paddr > 8'h18 || paddr[1:0] != 2'b00)
      |=> pslverr)
    else $error("unmapped access not refused");
  // ==========================================================
  // Covers
  op_run_c: cover property ($rose(busy_q));
  op_done_c: cover property ($rose(memory_interrupt_flag));
  op_abort_c: cover property (busy_q && abort_watchdog);
endmodule // deec_props

/* File: deec_cpu.sv */
`timescale 1ns/100ps
// ==========================================================
// Processor core model, APB master
module deec_cpu (
  input  wire        pclk,
  input  wire        pready,
  input  wire [31:0] prdata,
  input  wire        pslverr,
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [7:0]  paddr,
  output reg  [31:0] pwdata
);
  int hangs = 0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // One transfer, held until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) hangs++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule // deec_cpu

/* File: data_eeprom_controller_bench.sv */
`timescale 1ns/100ps
`include "deec_regs.vh"
// ==========================================================
// Bench top
module data_eeprom_controller_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        abort_pin_reset = 1'b0;
  logic        abort_watchdog = 1'b0;
  wire         psel, penable, pwrite, pready, pslverr, busy_q, memory_interrupt_flag;
  wire  [7:0]  paddr;
  wire  [31:0] pwdata, prdata;
  int          num_errors = 0;
  int          compares = 0;
  logic [31:0] q;
  logic        e;
  always #5 pclk = ~pclk;
  deec_cpu cpu (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  deec_ctrl #(.OP_WAIT(16'h0002)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .abort_pin_reset(abort_pin_reset), .abort_watchdog(abort_watchdog), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy_q(busy_q),
    .memory_interrupt_flag(memory_interrupt_flag));
  // ==========================================================
  // Helpers
  task automatic tally_and_finish;
    num_errors += cpu.hangs;
    $display("Checks %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d, q, e);
    if (cpu.hangs != 0) tally_and_finish;
  endtask
  task automatic rd(input logic [7:0] a);
    cpu.xfer(1'b0, a, 32'h0, q, e);
    if (cpu.hangs != 0) tally_and_finish;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input string nm);
    rd(a);
    chk(nm, q, x);
  endtask
  task automatic tbl(input logic [23:0] ad, input logic [15:0] d, input logic w);
    wr(`DEEC_OFF_PAGE, {24'h0, ad[23:16]});
    wr(`DEEC_OFF_TOFS, {16'h0, ad[15:0]});
    if (w) wr(`DEEC_OFF_TLOW, {16'h0, d});
    else rd(`DEEC_OFF_TLOW);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (2) @(posedge pclk);
    #1;
    while (busy_q === 1'b1 && n < 1000) begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (n >= 1000) num_errors++;
    if (n >= 1000) tally_and_finish;
  endtask
  task automatic op(input logic [15:0] c);
    wr(`DEEC_OFF_KEY, 32'h55);
    wr(`DEEC_OFF_KEY, 32'haa);
    wr(`DEEC_OFF_CTRL, {16'h0, c});
    wait_idle;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rdchk(`DEEC_OFF_CTRL, 32'h0, "ctrl reset");
    rdchk(`DEEC_OFF_KEY, 32'h0, "key read");
    rdchk(`DEEC_OFF_STAT, 32'h0, "status reset");
    rdchk(`DEEC_OFF_THIGH, 32'h0, "high word");
    rd(8'h1c);
    chk("unmapped err", {31'h0, e}, 32'h1);
  endtask
  task automatic t_locked;
    wr(`DEEC_OFF_CTRL, 32'hc004);
    rdchk(`DEEC_OFF_CTRL, 32'h4004, "no key");
    wr(`DEEC_OFF_KEY, 32'h55);
    wr(`DEEC_OFF_PAGE, 32'h7f);
    wr(`DEEC_OFF_KEY, 32'haa);
    wr(`DEEC_OFF_CTRL, 32'hc004);
    rdchk(`DEEC_OFF_CTRL, 32'h4004, "write between keys");
    wr(`DEEC_OFF_KEY, 32'haa);
    wr(`DEEC_OFF_KEY, 32'h55);
    wr(`DEEC_OFF_CTRL, 32'hc004);
    rdchk(`DEEC_OFF_CTRL, 32'h4004, "reversed keys");
    wr(`DEEC_OFF_KEY, 32'h55);
    wr(`DEEC_OFF_KEY, 32'haa);
    wr(`DEEC_OFF_STAT, 32'h0);
    wr(`DEEC_OFF_CTRL, 32'hc004);
    rdchk(`DEEC_OFF_CTRL, 32'h4004, "window closed");
    op(16'h8004);
    rdchk(`DEEC_OFF_CTRL, 32'h0004, "no enable");
    rdchk(`DEEC_OFF_STAT, 32'h0, "nothing ran");
  endtask
  task automatic t_word;
    tbl(24'h7fffff, 16'h1234, 1'b1);
    wr(`DEEC_OFF_STAT, 32'h1);
    op(16'hc004);
    rdchk(`DEEC_OFF_CTRL, 32'h0004, "ctrl after write");
    rdchk(`DEEC_OFF_STAT, 32'h1, "done flag");
    tbl(24'h7ffffe, 16'h0, 1'b0);
    chk("top word", q, 32'h1234);
    tbl(24'h7ffffe, 16'h00ff, 1'b1);
    op(16'hd004);
    tbl(24'h7ffffe, 16'h0, 1'b0);
    chk("program only", q, 32'h0034);
    tbl(24'h7ffffe, 16'h0f00, 1'b1);
    op(16'hc004);
    tbl(24'h7ffffe, 16'h0, 1'b0);
    chk("auto erase", q, 32'h0f00);
  endtask
  task automatic t_erase;
    logic [23:0] b;
    int          n;
    for (int k = 0; k < 3; k++) begin
      b = 24'h7ffe00 + 24'h40 * k;
      n = (k == 0) ? 1 : (k == 1) ? 4 : 8;
      for (int i = 0; i < 9; i++) begin
        tbl(b + 2 * i, 16'h0, 1'b1);
        op(16'hc004);
      end
      tbl(b, 16'h0, 1'b1);
      op(16'hc058 + k);
      for (int i = 0; i < 9; i++) begin
        tbl(b + 2 * i, 16'h0, 1'b0);
        chk("partial erase", q, (i < n) ? 32'hffff : 32'h0);
      end
    end
  endtask
  task automatic t_bulk;
    logic [23:0] a;
    tbl(24'h000100, 16'h0, 1'b1);
    op(16'hc053);
    for (int i = 0; i < 3; i++) begin
      a = (i == 2) ? 24'h7ffffe : 24'h7ffe50 + 24'h40 * i;
      tbl(a, 16'h0, 1'b0);
      chk("bulk erase", q, 32'hffff);
    end
  endtask
  task automatic t_abort;
    for (int k = 0; k < 2; k++) begin
      wr(`DEEC_OFF_STAT, 32'h1);
      wr(`DEEC_OFF_KEY, 32'h55);
      wr(`DEEC_OFF_KEY, 32'haa);
      wr(`DEEC_OFF_CTRL, 32'hc050);
      @(posedge pclk);
      abort_pin_reset <= (k == 0);
      abort_watchdog <= (k == 1);
      @(posedge pclk);
      abort_pin_reset <= 1'b0;
      abort_watchdog <= 1'b0;
      wait_idle;
      rdchk(`DEEC_OFF_CTRL, 32'h2050, "abort ctrl");
      rdchk(`DEEC_OFF_STAT, 32'h0, "abort flag");
    end
    op(16'he004);
    rdchk(`DEEC_OFF_CTRL, 32'h0004, "error cleared on finish");
    rdchk(`DEEC_OFF_STAT, 32'h1, "finish after abort");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset;
    t_locked;
    t_word;
    t_erase;
    t_bulk;
    t_abort;
    tally_and_finish;
  end
  initial begin
    #900000;
    num_errors++;
    tally_and_finish;
  end
endmodule // data_eeprom_controller_bench

bind deec_ctrl deec_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .abort_pin_reset(abort_pin_reset), .abort_watchdog(abort_watchdog), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .busy_q(busy_q),
  .memory_interrupt_flag(memory_interrupt_flag));
